// ### src/sod_decoder.sv
// SPI op code decoder with label table, divider and receive word FIFO.
`timescale 1ns/10ps

module sod_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic clear, // Empties the buffer.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [W-1:0] in_data, // Word in.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Word taken.
  output logic [W-1:0] out_data, // Oldest word.
  output logic [$clog2(D+1)-1:0] count // Words held.
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = count != ($clog2(D+1))'(D);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (($clog2(D+1))'(push)) - (($clog2(D+1))'(pop));
    end
  end
endmodule

module sod_decoder import sod_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // 50 MHz system clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic sck, // Serial clock pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic si, // Serial data in pin.
  output logic so, // Serial data out pin.
  output logic so_oe, // High while the data out pin is driven.
  input wire logic clear_pin, // Master clear request pin, active high.
  input wire logic aclk, // ARINC timing input pin.
  input wire logic rx_valid, // Received word offered by receiver.
  output logic rx_ready, // FIFO can take a word.
  input wire logic [WORD_W-1:0] rx_word, // Received word.
  output logic master_clear, // Clear strobe to the receiver.
  output logic [255:0] label_accept, // Label acceptance table.
  output logic [15:0] ctrl_reg, // Control register.
  output logic [7:0] aclk_divisor, // Stored divisor.
  output logic arinc_tick, // Receiver timing strobe.
  output logic rflag // FIFO empty or full flag.
);
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sck_d;
  logic aclk_d;
  logic cs_meta;
  logic sck_s;
  logic cs_act;
  logic si_s;
  logic clr_s;
  logic aclk_s;
  logic sck_rise;
  logic sck_fall;
  logic aclk_rise;
  sod_state_t state;
  logic [CNT_W-1:0] bit_count;
  logic [7:0] op_shift;
  logic [7:0] op_code;
  logic [7:0] op_in;
  logic op_strobe;
  logic [15:0] data_shift;
  logic [15:0] data_in;
  logic [7:0] idx;
  logic [31:0] tx_shift;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic [$clog2(DEPTH+1)-1:0] fifo_count;
  logic [7:0] status;
  logic [3:0] div_cnt;
  logic [3:0] ratio;
  logic div_ok;
  logic div_tick;

  // Serial clocks must stay well below a quarter of clk, since pins are sampled, not clocked from.
  always_ff @(posedge clk) begin
    sync1 <= {aclk, clear_pin, si, sck};
    sync2 <= sync1;
    sck_d <= sync2[0];
    aclk_d <= sync2[3];
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_meta <= 1'b0;
      cs_act <= 1'b0;
    end else begin
      cs_meta <= ~cs_n;
      cs_act <= cs_meta;
    end
  end
  assign sck_s = sync2[0];
  assign si_s = sync2[1];
  assign clr_s = sync2[2];
  assign aclk_s = sync2[3];
  assign sck_rise = cs_act && sck_s && !sck_d;
  assign sck_fall = cs_act && !sck_s && sck_d;
  assign aclk_rise = aclk_s && !aclk_d;
  assign op_in = {op_shift[6:0], si_s};
  assign data_in = {data_shift[14:0], si_s};
  assign idx = 8'(bit_count - CNT_DATA_FIRST);
  // eighth rising edge completes the op code
  assign op_strobe = sck_rise && state == ST_OPCODE && bit_count == CNT_OP_LAST;
  assign status = {5'h00, ~rx_ready, fifo_count >= ($clog2(DEPTH+1))'(DEPTH / 2), ~fifo_valid};
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      bit_count <= '0;
    end else if (sck_rise && bit_count != CNT_MAX) begin
      bit_count <= bit_count + 1'b1;
    end
  end

  // op code shifts in MSB first
  always_ff @(posedge clk) begin
    if (reset) begin
      op_shift <= 8'h00;
    end else if (sck_rise && state == ST_OPCODE) begin
      op_shift <= op_in;
    end
  end
  // undefined and out-of-range codes fall into the ignore state
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      state <= ST_OPCODE;
      op_code <= 8'h00;
    end else if (op_strobe) begin
      op_code <= op_in;
      unique case (op_in)
        OP_CLEAR_ONE, OP_SET_ONE, OP_LOAD_TABLE, OP_WRITE_DIV, OP_WRITE_CTRL: state <= ST_WRITE;
        OP_READ_FIFO, OP_READ_STATUS, OP_READ_CTRL, OP_READ_DIV, OP_READ_TABLE: state <= ST_READ;
        default: state <= ST_IGNORE;
      endcase
    end
  end
  // data field MSB first after the op code
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      data_shift <= 16'h0000;
    end else if (sck_rise && state == ST_WRITE) begin
      data_shift <= data_in;
    end
  end

  // master clear from the op code or the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      master_clear <= 1'b0;
    end else begin
      master_clear <= clr_s || (op_strobe && op_in == OP_MASTER_CLEAR);
    end
  end

  // set and clear instructions act while select is still low
  always_ff @(posedge clk) begin
    if (reset) begin
      label_accept <= '0;
    end else if (op_strobe && op_in == OP_CLEAR_ALL) begin
      label_accept <= '0;
    end else if (op_strobe && op_in == OP_SET_ALL) begin
      label_accept <= '1;
    end else if (sck_rise && state == ST_WRITE) begin
      if (op_code == OP_CLEAR_ONE && bit_count == CNT_BYTE_LAST) begin
        label_accept[data_in[7:0]] <= 1'b0;
      end else if (op_code == OP_SET_ONE && bit_count == CNT_BYTE_LAST) begin
        label_accept[data_in[7:0]] <= 1'b1;
      end else if (op_code == OP_LOAD_TABLE && bit_count <= CNT_TABLE_LAST) begin
        label_accept[~idx] <= si_s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aclk_divisor <= DIV_RESET;
    end else if (sck_rise && state == ST_WRITE && op_code == OP_WRITE_DIV && bit_count == CNT_BYTE_LAST) begin
      aclk_divisor <= data_in[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (sck_rise && state == ST_WRITE && op_code == OP_WRITE_CTRL && bit_count == CNT_HALF_LAST) begin
      ctrl_reg <= data_in;
    end
  end

  // read word loaded at the op code, empty reads zero
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      tx_shift <= 32'h0000_0000;
    end else if (op_strobe) begin
      unique case (op_in)
        OP_READ_FIFO: tx_shift <= fifo_valid ? fifo_data : 32'h0000_0000;
        OP_READ_STATUS: tx_shift <= {status, 24'h000000};
        OP_READ_CTRL: tx_shift <= {ctrl_reg, 16'h0000};
        OP_READ_DIV: tx_shift <= {aclk_divisor, 24'h000000};
        default: tx_shift <= 32'h0000_0000;
      endcase
    end else if (sck_fall && state == ST_READ) begin
      tx_shift <= {tx_shift[30:0], 1'b0};
    end
  end
  // MSB leaves at the first falling edge after the op code
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_oe <= 1'b1;
      if (sck_fall && state == ST_READ) begin
        // table read from label FF downward
        so <= (op_code != OP_READ_TABLE) ? tx_shift[31] : (bit_count <= CNT_TABLE_LAST) && label_accept[~idx];
      end
    end
  end
  sod_fifo #(.W(WORD_W), .D(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .clear(master_clear),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_word),
    .out_valid(fifo_valid),
    .out_ready(op_strobe && op_in == OP_READ_FIFO),
    .out_data(fifo_data),
    .count(fifo_count)
  );
  always_ff @(posedge clk) begin
    if (reset) begin
      rflag <= 1'b0;
    end else begin
      rflag <= ctrl_reg[CTRL_FLAG_DEF_BIT] ? ~rx_ready : ~fifo_valid;
    end
  end

  // only the listed ratios yield a divided clock
  always_comb begin
    ratio = aclk_divisor[3:0];
    div_ok = ratio == DIV_BY_1 || ratio == DIV_BY_2 || ratio == DIV_BY_4 || ratio == DIV_BY_8 || ratio == DIV_BY_10;
  end
  // The host is trusted to make the divided rate 1 MHz; nothing here measures it.
  always_ff @(posedge clk) begin
    if (reset || !div_ok) begin
      div_cnt <= 4'h0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= aclk_rise && div_cnt >= ratio - 4'h1;
      if (aclk_rise) begin
        div_cnt <= (div_cnt >= ratio - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arinc_tick <= 1'b0;
    end else begin
      arinc_tick <= ctrl_reg[CTRL_CLK_SRC_BIT] ? div_tick : aclk_rise;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_UNDEF_NOP: assert property (op_strobe && (op_in == 8'h00 || op_in == 8'h09 || op_in == 8'h0E
    || op_in == 8'h0F) |=> $stable(label_accept) && $stable(ctrl_reg) && $stable(aclk_divisor) && state == ST_IGNORE)
    else $error("Undefined op code changed state.");
  AST_MCLEAR: assert property (op_strobe && op_in == OP_MASTER_CLEAR |=> master_clear ##1 !fifo_valid)
    else $error("Master clear op code did not clear.");
  AST_CLEAR_ALL: assert property (op_strobe && op_in == OP_CLEAR_ALL |=> label_accept == '0)
    else $error("Label table not cleared.");
  AST_SET_ALL: assert property (op_strobe && op_in == OP_SET_ALL |=> label_accept == '1)
    else $error("Label table not set.");
  AST_SET_ONE: assert property (sck_rise && state == ST_WRITE && op_code == OP_SET_ONE
    && bit_count == CNT_BYTE_LAST |=> label_accept[$past(data_in[7:0])])
    else $error("Single label not set.");
  AST_NO_DIV_CLOCK: assert property (!div_ok |=> !div_tick)
    else $error("Divided tick without a legal ratio.");
  AST_SRC_SEL: assert property (arinc_tick
    |-> ($past(ctrl_reg[CTRL_CLK_SRC_BIT]) ? $past(div_tick) : $past(aclk_rise)))
    else $error("Receiver tick from wrong source.");
  AST_EMPTY_READ: assert property (op_strobe && op_in == OP_READ_FIFO && !fifo_valid |=> tx_shift == 32'h0000_0000)
    else $error("Empty FIFO read not zero.");
  AST_CTRL_WRITE: assert property (sck_rise && state == ST_WRITE && op_code == OP_WRITE_CTRL
    && bit_count == CNT_HALF_LAST |=> ctrl_reg == $past(data_in))
    else $error("Control register not loaded.");
  AST_DESELECT: assert property (!cs_act |=> bit_count == '0 && state == ST_OPCODE)
    else $error("Deselect did not end the transaction.");

  COV_TABLE_LOAD: cover property (sck_rise && op_code == OP_LOAD_TABLE && bit_count == CNT_TABLE_LAST);
  COV_FIFO_READ: cover property (op_strobe && op_in == OP_READ_FIFO && fifo_valid);
  COV_CTRL_WRITE: cover property (sck_rise && op_code == OP_WRITE_CTRL && bit_count == CNT_HALF_LAST);
  COV_DIV_TICK: cover property (div_tick && ctrl_reg[CTRL_CLK_SRC_BIT]);
endmodule

// ### include/sod_pkg.sv
// Constants and types for the SPI op code decoder of the ARINC receiver.
// Contract
// - Op codes 00, 09, 0E and 0F do nothing and change no state.
// - Op code 01 performs the master clear after the eighth op code bit.
// - Op code 02 clears every label acceptance entry after the eighth bit.
// - Op code 03 sets every label acceptance entry after the eighth bit.
// - Op code 04 clears the single label entry addressed by an 8-bit field.
// - Op code 05 sets the single label entry addressed by an 8-bit field.
// - Op code 06 writes 256 label entries from label FF downward.
// - Op code 07 stores divisor; low nibble 1,2,4,8,A divides, others give no clock.
// - With clock source bit set, the receiver runs from the divided timing clock.
// - Op code 08 shifts out next FIFO word and pops it; empty gives zeros.
// - Op code 0A shifts out the 8-bit status register.
// - Op code 0B shifts out the 16-bit control register.
// - Op code 0C shifts out the stored 8-bit divisor.
// - Op code 0D shifts out all 256 label entries starting at label FF.
// - Op code 10 loads the following 16-bit field into the control register.
// - First eight rising serial clocks after select capture the op code, MSB first.
// - Write data MSB follows the op code and is taken at the next rising edge.
// - Read data MSB appears at the first falling edge after the op code.
// - Reset and set instructions act after the last input bit, select still low.
package sod_pkg;
  localparam logic [7:0] OP_MASTER_CLEAR = 8'h01;
  localparam logic [7:0] OP_CLEAR_ALL = 8'h02;
  localparam logic [7:0] OP_SET_ALL = 8'h03;
  localparam logic [7:0] OP_CLEAR_ONE = 8'h04;
  localparam logic [7:0] OP_SET_ONE = 8'h05;
  localparam logic [7:0] OP_LOAD_TABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DIV = 8'h07;
  localparam logic [7:0] OP_READ_FIFO = 8'h08;
  localparam logic [7:0] OP_READ_STATUS = 8'h0A;
  localparam logic [7:0] OP_READ_CTRL = 8'h0B;
  localparam logic [7:0] OP_READ_DIV = 8'h0C;
  localparam logic [7:0] OP_READ_TABLE = 8'h0D;
  localparam logic [7:0] OP_WRITE_CTRL = 8'h10;
  localparam int CNT_W = 9;
  localparam logic [8:0] CNT_OP_LAST = 9'h007;
  localparam logic [8:0] CNT_DATA_FIRST = 9'h008;
  localparam logic [8:0] CNT_BYTE_LAST = 9'h00F;
  localparam logic [8:0] CNT_HALF_LAST = 9'h017;
  localparam logic [8:0] CNT_TABLE_LAST = 9'h107;
  localparam logic [8:0] CNT_MAX = 9'h1FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam int CTRL_CLK_SRC_BIT = 1;
  localparam int CTRL_FLAG_DEF_BIT = 15;
  localparam logic [3:0] DIV_BY_1 = 4'h1;
  localparam logic [3:0] DIV_BY_2 = 4'h2;
  localparam logic [3:0] DIV_BY_4 = 4'h4;
  localparam logic [3:0] DIV_BY_8 = 4'h8;
  localparam logic [3:0] DIV_BY_10 = 4'hA;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 32;
  typedef enum logic [1:0] {ST_OPCODE, ST_WRITE, ST_READ, ST_IGNORE} sod_state_t;
endpackage

// ### sim/sod_spi_host.sv
// Behavioural SPI master that frames op codes and data fields for the decoder.
`timescale 1ns/10ps

module sod_spi_host (
  input wire logic clk, // System clock.
  input wire logic so, // Serial data from the decoder.
  output logic sck, // Serial clock, low outside frames.
  output logic cs_n, // Chip select, active low.
  output logic si // Serial data, low when idle.
);
  // Six clocks a level lets the decoder's synchronisers see every edge.
  localparam int HALF = 6;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic xfer(input logic [7:0] op, input logic [255:0] wdata, input int nbits,
    output logic [255:0] rdata);
    rdata = '0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    // op code then field, MSB first.
    for (int i = 0; i < nbits + 8; i++) begin
      si = (i < 8) ? op[7 - i] : wdata[nbits + 7 - i];
      repeat (HALF) @(negedge clk);
      if (i >= 8) begin
        rdata = {rdata[254:0], so};
      end
      sck = 1'b1;
      repeat (HALF) @(negedge clk);
      sck = 1'b0;
    end
    si = 1'b0;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ### sim/test_spi_opcode_decoder_a429_rx.sv
// Self-checking bench for the SPI op code decoder.
`timescale 1ns/10ps

module test_spi_opcode_decoder_a429_rx import sod_pkg::*;;
  logic clk, reset, clear_pin, aclk, rx_valid;
  logic [WORD_W-1:0] rx_word;
  logic sck, cs_n, si, so, so_oe, rx_ready, master_clear, arinc_tick, rflag;
  logic [255:0] label_accept, rd, tab;
  logic [15:0] ctrl_reg;
  logic [7:0] aclk_divisor;
  int miscompares, n_compared, n_tick, n_clear, n_oe, cycles, got;

  sod_decoder #(.DEPTH(FIFO_DEPTH)) uut (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .clear_pin(clear_pin), .aclk(aclk), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_word(rx_word), .master_clear(master_clear), .label_accept(label_accept), .ctrl_reg(ctrl_reg),
    .aclk_divisor(aclk_divisor), .arinc_tick(arinc_tick), .rflag(rflag));
  sod_spi_host host (.clk(clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (arinc_tick === 1'b1) n_tick++;
    if (master_clear === 1'b1) n_clear++;
    if (so_oe === 1'b1) n_oe++;
    if (cycles == 60000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] seen);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offers words with valid held high, also while the buffer refuses them.
  task automatic push(input int n);
    got = 0;
    repeat (n) begin
      @(negedge clk);
      rx_word = 32'hC0DE0000 + got;
      rx_valid = 1'b1;
      if (rx_ready === 1'b1) got++;
    end
    @(negedge clk);
    rx_valid = 1'b0;
  endtask

  task automatic count_ticks();
    repeat (10) @(negedge clk);
    n_tick = 0;
    repeat (40) begin
      aclk = 1'b1;
      repeat (4) @(negedge clk);
      aclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (10) @(negedge clk);
  endtask

  task automatic t_ctrl();
    chk("empty flag", 1, rflag);
    host.xfer(OP_WRITE_CTRL, 256'hA5C3, 16, rd);
    chk("ctrl_reg", 256'hA5C3, ctrl_reg);
    host.xfer(OP_READ_CTRL, '0, 16, rd);
    chk("read ctrl", 256'hA5C3, rd);
    chk("so_oe driven", 1, n_oe != 0);
    chk("so_oe idle", 0, so_oe);
    host.xfer(OP_WRITE_CTRL, 256'h1234, 10, rd);
    chk("partial ctrl", 256'hA5C3, ctrl_reg);
  endtask

  task automatic t_label();
    host.xfer(OP_SET_ALL, '0, 0, rd);
    chk("set all", {256{1'b1}}, label_accept);
    host.xfer(OP_CLEAR_ONE, 256'h3C, 8, rd);
    tab = {256{1'b1}};
    tab[8'h3C] = 1'b0;
    chk("clear one", tab, label_accept);
    host.xfer(OP_CLEAR_ALL, '0, 0, rd);
    chk("clear all", '0, label_accept);
    host.xfer(OP_SET_ONE, 256'hFF, 8, rd);
    chk("set one", 256'h1 << 255, label_accept);
    tab = (256'hB << 252) | 256'h1;
    host.xfer(OP_LOAD_TABLE, tab, 256, rd);
    chk("load table", tab, label_accept);
    host.xfer(OP_READ_TABLE, '0, 256, rd);
    chk("read table", tab, rd);
  endtask

  task automatic t_div();
    logic [3:0] nib [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'h3};
    host.xfer(OP_WRITE_DIV, 256'h5A, 8, rd);
    chk("divisor", 256'h5A, aclk_divisor);
    host.xfer(OP_READ_DIV, '0, 8, rd);
    chk("read divisor", 256'h5A, rd);
    host.xfer(OP_WRITE_CTRL, 256'h0, 16, rd);
    count_ticks();
    chk("undivided ticks", 40, n_tick);
    host.xfer(OP_WRITE_CTRL, 256'h2, 16, rd);
    // forty rises suit every legal divisor.
    foreach (nib[k]) begin
      host.xfer(OP_WRITE_DIV, {252'h0, nib[k]}, 8, rd);
      count_ticks();
      chk("divided ticks", (nib[k] == 4'h3) ? 0 : 40 / nib[k], n_tick);
    end
  endtask

  task automatic t_undef();
    logic [7:0] ops [6] = '{8'h00, 8'h09, 8'h0E, 8'h0F, 8'h11, 8'hFF};
    n_clear = 0;
    foreach (ops[k]) begin
      host.xfer(ops[k], 256'hFFFF, 16, rd);
      chk("ctrl kept", 256'h2, ctrl_reg);
      chk("table kept", tab, label_accept);
      chk("divisor kept", 256'h3, aclk_divisor);
    end
    chk("no clear", 0, n_clear);
  endtask

  task automatic t_fifo();
    host.xfer(OP_READ_STATUS, '0, 8, rd);
    chk("status empty", 256'h01, rd);
    push(20);
    chk("words taken", FIFO_DEPTH, got);
    host.xfer(OP_READ_STATUS, '0, 8, rd);
    chk("status full", 256'h06, rd);
    host.xfer(OP_WRITE_CTRL, 256'h8000, 16, rd);
    chk("full flag", 1, rflag);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      host.xfer(OP_READ_FIFO, '0, 32, rd);
      chk("fifo word", 32'hC0DE0000 + i, rd);
    end
    host.xfer(OP_READ_FIFO, '0, 32, rd);
    chk("empty read", 0, rd);
    push(2);
    n_clear = 0;
    host.xfer(OP_MASTER_CLEAR, '0, 0, rd);
    chk("clear strobes", 1, n_clear);
    host.xfer(OP_READ_STATUS, '0, 8, rd);
    chk("status cleared", 256'h01, rd);
    push(2);
    clear_pin = 1'b1;
    repeat (2) @(negedge clk);
    clear_pin = 1'b0;
    repeat (6) @(negedge clk);
    host.xfer(OP_READ_STATUS, '0, 8, rd);
    chk("status after pin clear", 256'h01, rd);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clear_pin = 1'b0;
    aclk = 1'b0;
    rx_valid = 1'b0;
    rx_word = '0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_ctrl();
    t_label();
    t_div();
    t_undef();
    t_fifo();
    test_done();
  end
endmodule
